/* File: shared/bss_pkg.sv */
/*
 * shared constants for the burner safety sequencer: timings, flash
 * symbols and codes, sequence states and lock-out causes.
 * assumes a single 20 MHz clock and a 100 ms tick made by a divider.
 */
package bss_pkg;

   // clock and tick
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

   // sequence times in ms, then in ticks
   localparam int PREHEAT_WAIT_LIMIT_MS = 400_000;
   localparam int PREPURGE_TIME_MS = 20_000;
   localparam int STRAY_CHECK_TIME_MS = 5_000;
   localparam int SAFETY_WINDOW_MS = 5_000;
   localparam int POST_IGNITE_TIME_MS = 7_000;
   localparam int SECOND_STAGE_DELAY_MS = 20_000;
   localparam int POSTPURGE_MS = 60_000;
   localparam int HOLD_MS = 3_000;
   localparam int PWR_FAN_MS = 2_500;
   localparam int LK_LIT_MS = 10_000;
   localparam int LK_DARK_MS = 600;
   localparam int LK_CODE_MS = 1_200;
   localparam int PREHEAT_T = PREHEAT_WAIT_LIMIT_MS / TICK_MS;
   localparam int PREPURGE_T = PREPURGE_TIME_MS / TICK_MS;
   localparam int STRAY_T = STRAY_CHECK_TIME_MS / TICK_MS;
   localparam int SAFETY_T = SAFETY_WINDOW_MS / TICK_MS;
   localparam int POSTIGN_T = POST_IGNITE_TIME_MS / TICK_MS;
   localparam int STAGE2_T = SECOND_STAGE_DELAY_MS / TICK_MS;
   localparam int POSTPURGE_T = POSTPURGE_MS / TICK_MS;
   localparam int HOLD_T = HOLD_MS / TICK_MS;
   localparam int PWRFAN_T = PWR_FAN_MS / TICK_MS;
   localparam int LK_LIT_T = LK_LIT_MS / TICK_MS;
   localparam int LK_DARK_T = LK_DARK_MS / TICK_MS;
   localparam int LK_CYCLE_T = (LK_LIT_MS + LK_DARK_MS + LK_CODE_MS) / TICK_MS;

   // flash element lengths in ticks
   localparam int FL_SHORT_T = 1;
   localparam int FL_LONG_T = 3;
   localparam int FL_GAP_T = 1;
   localparam int FL_PAUSE_T = 3;

   // flash symbols, symbol 0 in the low bits of a code
   localparam logic [1:0] SYM_END = 2'h0;
   localparam logic [1:0] SYM_SHORT = 2'h1;
   localparam logic [1:0] SYM_LONG = 2'h2;
   localparam logic [1:0] SYM_PAUSE = 2'h3;
   localparam logic [15:0] CODE_PREHEAT = 16'h0035;
   localparam logic [15:0] CODE_PREIGNITE = 16'h0355;
   localparam logic [15:0] CODE_SAFETY = 16'h0036;
   localparam logic [15:0] CODE_DELAY2 = 16'h0356;
   localparam logic [15:0] CODE_RUN = 16'h000d;
   localparam logic [15:0] CODE_LOWV = 16'h003a;
   localparam logic [15:0] CODE_POSTPURGE = 16'h000e;
   localparam logic [15:0] CODE_NOFLAME = 16'h0002;
   localparam logic [15:0] CODE_STRAY = 16'h0009;
   localparam logic [15:0] CODE_THERMO = 16'h0025;
   localparam logic [15:0] CODE_MANUAL = 16'h000a;

   typedef enum logic [3:0] {
      S_INIT = 4'h0, S_PWRFAN = 4'h1, S_LOWV = 4'h2, S_PREHEAT = 4'h3,
      S_PREPURGE = 4'h4, S_SAFETY = 4'h5, S_DELAY2 = 4'h6, S_RUN = 4'h7,
      S_POSTPURGE = 4'h8, S_LOCK = 4'h9
   } bss_state_t;

   typedef enum logic [2:0] {
      C_NONE = 3'h0, C_NOFLAME = 3'h1, C_STRAY = 3'h2, C_THERMO = 3'h3,
      C_MANUAL = 3'h4
   } bss_cause_t;

endpackage

/* File: hdl/bss_sync.sv */
/*
 * two-flop synchroniser for a bundle of slow pins.
 * assumes the pins are quasi-static compared with clk.
 */
`timescale 1ns/1ps
module bss_sync #(
   parameter int W = 7
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] pins,
   output logic [W-1:0] sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bss_sync_t;

   bss_sync_t st;
   bss_sync_t next_st;

   if (W < 1) begin : g_bad_width
      $error("bss_sync width must be at least one");
   end

   // first stage feeds only the second
   always_comb begin
      next_st.s1 = pins;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync = st.s2;
endmodule

/* File: hdl/bss_flash.sv */
/*
 * flash code player: walks up to eight symbols of a code on the tick.
 * assumes kick and tick come from logic on clk; done pulses at the end.
 */
`timescale 1ns/1ps
module bss_flash (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic kick,
   input wire logic [15:0] code,
   output logic led,
   output logic done
);
   import bss_pkg::*;

   typedef struct packed {
      logic [2:0] idx;
      logic [1:0] cnt;
      logic pulse;
      logic busy;
      logic led;
      logic done;
   } bss_flash_t;

   bss_flash_t st;
   bss_flash_t next_st;

   if (FL_LONG_T > 3 || FL_PAUSE_T > 3 || FL_SHORT_T < 1 || FL_GAP_T < 1) begin : g_bad_len
      $error("flash element lengths must lie in 1..3 ticks");
   end

   // start one symbol; an end symbol closes the code
   function automatic bss_flash_t load(bss_flash_t s, logic [2:0] i);
      logic [1:0] sym;
      sym = code[{i, 1'b0} +: 2];
      s.idx = i;
      s.busy = (sym != SYM_END);
      s.done = (sym == SYM_END);
      s.led = (sym == SYM_SHORT) || (sym == SYM_LONG);
      s.pulse = s.led;
      case (sym)
         SYM_SHORT: s.cnt = 2'(FL_SHORT_T);
         SYM_LONG: s.cnt = 2'(FL_LONG_T);
         SYM_PAUSE: s.cnt = 2'(FL_PAUSE_T);
         default: s.cnt = 2'h0;
      endcase
      return s;
   endfunction

   // every pulse is followed by a short gap before the next symbol
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (kick) begin
         next_st = load(st, 3'h0);
      end else if (st.busy && tick) begin
         if (st.cnt > 2'h1) begin
            next_st.cnt = st.cnt - 2'h1;
         end else if (st.pulse) begin
            next_st.pulse = 1'b0;
            next_st.led = 1'b0;
            next_st.cnt = 2'(FL_GAP_T);
         end else if (st.idx == 3'h7) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end else begin
            next_st = load(st, st.idx + 3'h1);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign led = st.led;
   assign done = st.done;
endmodule

/* File: hdl/bss_sequencer.sv */
/*
 * burner safety sequencer: start-up phases, flame and mains supervision,
 * recycling after flame loss, lock-out with stored cause, led codes.
 * assumes all inputs are pins, a nonvolatile cell outside that holds
 * nv_cause when nv_write pulses, and an outside comparator with hysteresis
 * that raises undervolt_in below the lower mains level.
 */
`timescale 1ns/1ps

module bss_sequencer #(
   parameter bit PREHEATER = 1'b0,
   parameter int TICK_CYC = bss_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic flame_in,
   input wire logic undervolt_in,
   input wire logic release_in,
   input wire logic button_in,
   input wire logic [2:0] nv_stored,
   output logic fan,
   output logic ignition,
   output logic first_stage_valve,
   output logic second_stage_valve,
   output logic override,
   output logic alarm,
   output logic led,
   output bss_pkg::bss_cause_t nv_cause,
   output logic nv_write
);
   import bss_pkg::*;

   typedef struct packed {
      bss_state_t state;
      bss_cause_t cause;
      logic [21:0] div;
      logic tick;
      logic [11:0] tmr;
      logic [6:0] lk;
      logic [5:0] hold;
      logic btn_prev;
      logic [15:0] code;
      logic fl_kick;
      logic fan;
      logic ign;
      logic v1;
      logic v2;
      logic ovr;
      logic alarm;
      logic led;
      logic nv_write;
   } bss_main_t;

   bss_main_t st;
   bss_main_t next_st;
   logic [6:0] pin_s;
   logic flame;
   logic uv;
   logic rel;
   logic btn;
   bss_cause_t stored;
   logic fl_led;
   logic fl_done;
   logic btn_fall;

   if (TICK_CYC < 2 || TICK_CYC > 4_194_304) begin : g_bad_tick
      $error("TICK_CYC must lie in 2..2**22");
   end

   // every pin crosses two flops before anything reads it
   bss_sync #(.W(7)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .pins({nv_stored, button_in, release_in, undervolt_in, flame_in}),
      .sync(pin_s)
   );

   assign flame = pin_s[0];
   assign uv = pin_s[1];
   assign rel = pin_s[2];
   assign btn = pin_s[3];
   assign stored = bss_cause_t'(pin_s[6:4]);
   assign btn_fall = st.btn_prev && !btn;

   bss_flash u_flash (
      .clk(clk),
      .arst_n(arst_n),
      .tick(st.tick),
      .kick(st.fl_kick),
      .code(st.code),
      .led(fl_led),
      .done(fl_done)
   );

   // enter a phase with a fresh timer
   function automatic bss_main_t go(bss_main_t s, bss_state_t to);
      s.state = to;
      s.tmr = 12'h000;
      s.lk = 7'h00;
      return s;
   endfunction

   // enter lock-out and write the cause out to the nonvolatile cell
   function automatic bss_main_t lock(bss_main_t s, bss_cause_t c);
      s = go(s, S_LOCK);
      s.cause = c;
      s.nv_write = 1'b1;
      return s;
   endfunction

   // first phase of a start cycle depends on the variant
   function automatic bss_state_t first_phase();
      return PREHEATER ? S_PREHEAT : S_PREPURGE;
   endfunction

   // phases in which the burner is being started, is firing or is post-purging
   function automatic logic active(bss_state_t s);
      return (s == S_PREHEAT) || (s == S_PREPURGE) || (s == S_SAFETY) ||
         (s == S_DELAY2) || (s == S_RUN) || (s == S_POSTPURGE);
   endfunction

   // flash code for a phase, or the cause code during lock-out
   function automatic logic [15:0] code_of(bss_state_t s, bss_cause_t c,
         logic [11:0] t);
      logic [15:0] r;
      r = CODE_RUN;
      case (s)
         S_PREHEAT: r = CODE_PREHEAT;
         S_PREPURGE: r = CODE_PREIGNITE;
         S_SAFETY: r = CODE_SAFETY;
         S_DELAY2: r = (t < 12'(POSTIGN_T)) ? CODE_SAFETY : CODE_DELAY2;
         S_RUN: r = CODE_RUN;
         S_LOWV, S_INIT: r = CODE_LOWV;
         S_POSTPURGE, S_PWRFAN: r = CODE_POSTPURGE;
         S_LOCK: begin
            case (c)
               C_NOFLAME: r = CODE_NOFLAME;
               C_STRAY: r = CODE_STRAY;
               C_THERMO: r = CODE_THERMO;
               default: r = CODE_MANUAL;
            endcase
         end
         default: r = CODE_RUN;
      endcase
      return r;
   endfunction

   // sequence, timers, button and outputs
   always_comb begin
      next_st = st;
      next_st.nv_write = 1'b0;
      next_st.fl_kick = 1'b0;
      next_st.btn_prev = btn;
      next_st.tick = (st.div == 22'(TICK_CYC - 1));
      next_st.div = next_st.tick ? 22'h00_0000 : st.div + 22'h00_0001;
      if (st.tick) begin
         next_st.tmr = st.tmr + 12'h001;
      end
      // hold time of the button, saturating
      if (!btn) begin
         next_st.hold = 6'h00;
      end else if (st.tick && st.hold != 6'h3f) begin
         next_st.hold = st.hold + 6'h01;
      end

      case (st.state)
         S_INIT: begin
            // one tick lets the synchronised stored cause settle
            if (st.tick) begin
               if (stored != C_NONE) begin
                  next_st = go(next_st, S_PWRFAN);
                  next_st.cause = stored;
               end else begin
                  next_st = go(next_st, S_LOWV);
               end
            end
         end
         S_PWRFAN: begin
            if (st.tick && st.tmr == 12'(PWRFAN_T - 1)) begin
               next_st = go(next_st, S_LOCK);
            end
         end
         S_LOWV: begin
            if (!uv) begin
               next_st = go(next_st, first_phase());
            end
         end
         S_PREHEAT: begin
            if (rel) begin
               next_st = go(next_st, S_PREPURGE);
            end else if (st.tick && st.tmr == 12'(PREHEAT_T - 1)) begin
               next_st = lock(next_st, C_THERMO);
            end
         end
         S_PREPURGE: begin
            // stray light watched over the last part of pre-purge
            if (flame && st.tmr >= 12'(PREPURGE_T - STRAY_T)) begin
               next_st = lock(next_st, C_STRAY);
            end else if (st.tick && st.tmr == 12'(PREPURGE_T - 1)) begin
               next_st = go(next_st, S_SAFETY);
            end
         end
         S_SAFETY: begin
            if (st.tick && st.tmr == 12'(SAFETY_T - 1)) begin
               if (flame) begin
                  next_st.state = S_DELAY2; // timer keeps counting from first valve
               end else begin
                  next_st = lock(next_st, C_NOFLAME);
               end
            end
         end
         S_DELAY2: begin
            if (!flame) begin
               next_st = go(next_st, S_POSTPURGE);
            end else if (st.tick && st.tmr == 12'(STAGE2_T - 1)) begin
               next_st = go(next_st, S_RUN);
            end
         end
         S_RUN: begin
            if (!flame) begin
               next_st = go(next_st, S_POSTPURGE);
            end
         end
         S_POSTPURGE: begin
            if (st.tick && st.tmr == 12'(POSTPURGE_T - 1)) begin
               next_st = go(next_st, first_phase());
            end
         end
         S_LOCK: begin
            // report cycle: lit, dark, then the cause code window
            if (st.tick) begin
               next_st.lk = (st.lk == 7'(LK_CYCLE_T - 1)) ? 7'h00 : st.lk + 7'h01;
               next_st.fl_kick = (st.lk == 7'(LK_LIT_T + LK_DARK_T - 1));
            end
            if (btn_fall) begin
               next_st = go(next_st, first_phase());
               next_st.cause = C_NONE;
               next_st.nv_write = 1'b1;
            end
         end
         default: begin
            next_st = go(next_st, S_INIT);
         end
      endcase

      // mains drop stops any start or firing; a fault found now still wins
      if (active(st.state) && uv && next_st.state != S_LOCK) begin
         next_st = go(next_st, S_LOWV);
      end
      // long press then release forces lock-out
      if ((active(st.state) || st.state == S_LOWV) && btn_fall &&
            st.hold >= 6'(HOLD_T)) begin
         next_st = lock(next_st, C_MANUAL);
      end

      // outputs follow the next phase so they line up with the state
      next_st.fan = (next_st.state == S_PREPURGE) || (next_st.state == S_SAFETY) ||
         (next_st.state == S_DELAY2) || (next_st.state == S_RUN) ||
         (next_st.state == S_POSTPURGE) || (next_st.state == S_PWRFAN);
      next_st.ign = (next_st.state == S_PREPURGE) || (next_st.state == S_SAFETY) ||
         (next_st.state == S_DELAY2 && next_st.tmr < 12'(POSTIGN_T));
      next_st.v1 = (next_st.state == S_SAFETY) || (next_st.state == S_DELAY2) ||
         (next_st.state == S_RUN);
      next_st.v2 = (next_st.state == S_RUN);
      next_st.ovr = PREHEATER && flame &&
         ((next_st.state == S_DELAY2) || (next_st.state == S_RUN));
      next_st.alarm = (next_st.state == S_LOCK);

      // phase code restarts when it ends or when the code to show changes
      next_st.code = code_of(next_st.state, next_st.cause, next_st.tmr);
      if (next_st.state != S_LOCK && (fl_done || next_st.code != st.code)) begin
         next_st.fl_kick = 1'b1;
      end
      if (next_st.state != S_LOCK) begin
         next_st.led = fl_led;
      end else if (next_st.lk < 7'(LK_LIT_T)) begin
         next_st.led = 1'b1;
      end else if (next_st.lk < 7'(LK_LIT_T + LK_DARK_T)) begin
         next_st.led = 1'b0;
      end else begin
         next_st.led = fl_led;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fan = st.fan;
   assign ignition = st.ign;
   assign first_stage_valve = st.v1;
   assign second_stage_valve = st.v2;
   assign override = st.ovr;
   assign alarm = st.alarm;
   assign led = st.led;
   assign nv_cause = st.cause;
   assign nv_write = st.nv_write;

   // checks on the sequence
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence seq_flame_lost;
      (st.state == S_RUN || st.state == S_DELAY2) ##0 !flame;
   endsequence

   sequence seq_safety_end;
      st.state == S_SAFETY && st.tick && st.tmr == 12'(SAFETY_T - 1);
   endsequence

   a_lock_outputs_off: assert property (
      st.state == S_LOCK |-> alarm && !fan && !ignition && !first_stage_valve &&
         !second_stage_valve && !override)
      else $error("outputs active during lock-out");

   a_flame_loss_recycle: assert property (
      seq_flame_lost ##0 (!uv && !(btn_fall && st.hold >= 6'(HOLD_T)))
         |=> st.state == S_POSTPURGE && fan && !first_stage_valve &&
            !second_stage_valve)
      else $error("flame loss did not start post-purge with valves shut");

   a_valves_drop: assert property (
      seq_flame_lost |=> !first_stage_valve && !second_stage_valve)
      else $error("valves still open after flame loss");

   a_uv_stops: assert property (
      active(st.state) && uv |=> !first_stage_valve && !ignition &&
         (st.state == S_LOWV || st.state == S_LOCK))
      else $error("undervoltage did not stop the sequence");

   a_uv_holds: assert property (
      st.state == S_LOWV && uv && !btn_fall |=> st.state == S_LOWV)
      else $error("start repeated under low mains");

   a_noflame_lock: assert property (
      seq_safety_end ##0 (!flame && !uv && !(btn_fall && st.hold >= 6'(HOLD_T)))
         |=> st.state == S_LOCK && nv_cause == C_NOFLAME && nv_write)
      else $error("missing flame at end of safety time not locked");

   a_stray_lock: assert property (
      st.state == S_PREPURGE && flame && st.tmr >= 12'(PREPURGE_T - STRAY_T)
         && !(btn_fall && st.hold >= 6'(HOLD_T))
         |=> st.state == S_LOCK && nv_cause == C_STRAY)
      else $error("stray light not locked");

   a_reset_quick: assert property (
      st.state == S_LOCK && btn_fall |=> st.state == first_phase() && !alarm)
      else $error("lock-out reset did not restart at once");

   a_nv_records: assert property (
      $rose(st.state == S_LOCK) && $past(st.state) != S_PWRFAN |-> nv_write &&
         nv_cause != C_NONE)
      else $error("lock-out cause not written to storage");

   a_lock_lit: assert property (
      st.state == S_LOCK && st.lk == 7'h05 && $past(st.state) == S_LOCK
         && $past(st.lk) == 7'h05 |=> led)
      else $error("led dark in lit part of lock-out");

   a_stage2_no_ign: assert property (
      second_stage_valve |-> first_stage_valve && fan && !ignition)
      else $error("second stage open without first stage or with ignition");
endmodule

/* File: testbench/bss_burner_model.sv */
/*
 * far-side model of the burner: flame detector seeing the flame.
 * assumes flame_ok and stray are set by the bench between phases.
 */
`timescale 1ns/1ps
module bss_burner_model (
   input wire logic clk,
   input wire logic first_stage_valve,
   input wire logic flame_ok,
   input wire logic stray,
   output logic flame_in
);
   logic [3:0] lit = 4'h0;
   // flame builds a few cycles after fuel opens, dies with the fuel
   always @(posedge clk) begin
      lit <= {lit[2:0], first_stage_valve & flame_ok};
   end
   // stray light shows even with fuel shut
   assign flame_in = stray | (lit[3] & first_stage_valve & flame_ok);
endmodule

/* File: testbench/testbench.sv */
/*
 * self-checking bench for the burner safety sequencer.
 * assumes a shortened tick of 4 cycles and the burner model beside it.
 */
`timescale 1ns/1ps
module testbench;
   import bss_pkg::*;
   localparam int TK = 4;
   localparam int TOL = 3 * TK;
   localparam int CEIL = 40_000;
   logic clk, arst_n, flame_in, undervolt_in, release_in, button_in;
   logic [2:0] nv_stored;
   logic fan, ignition, first_stage_valve, second_stage_valve;
   logic override, alarm, led, nv_write, flame_ok, stray;
   bss_cause_t nv_cause, last_cause;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   int n, m;

   bss_sequencer #(.PREHEATER(1'b0), .TICK_CYC(TK)) i_bss_sequencer (
      .clk(clk), .arst_n(arst_n), .flame_in(flame_in), .undervolt_in(undervolt_in),
      .release_in(release_in), .button_in(button_in), .nv_stored(nv_stored),
      .fan(fan), .ignition(ignition), .first_stage_valve(first_stage_valve),
      .second_stage_valve(second_stage_valve), .override(override), .alarm(alarm),
      .led(led), .nv_cause(nv_cause), .nv_write(nv_write));
   bss_burner_model i_bss_burner_model (
      .clk(clk), .first_stage_valve(first_stage_valve), .flame_ok(flame_ok),
      .stray(stray), .flame_in(flame_in));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // remember what the nonvolatile cell would hold
   always @(posedge clk) begin
      if (nv_write === 1'b1) begin
         last_cause <= nv_cause;
      end
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == CEIL) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("errors %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic miss(input string msg);
      error_cnt++;
      $display("MISMATCH at %0t: %s", $time, msg);
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      tests_run++;
      if (got !== exp) miss(msg);
   endtask

   task automatic chk_cause(input bss_cause_t got, input bss_cause_t exp);
      tests_run++;
      if (got !== exp) miss("stored cause");
   endtask

   // durations are counted on negedges, so allow three ticks of slack
   task automatic chk_int(input int got, input int exp, input string msg);
      tests_run++;
      if (got < exp - TOL || got > exp + TOL) miss(msg);
   endtask

   function automatic logic sel(input int idx);
      case (idx)
         0: return fan;
         1: return ignition;
         2: return first_stage_valve;
         3: return second_stage_valve;
         4: return alarm;
         default: return led;
      endcase
   endfunction

   // bounded wait for an output level, cnt gives the cycles spent
   task automatic wait_sig(input int idx, input logic val, input int lim, output int cnt);
      cnt = 0;
      while (sel(idx) !== val && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
      if (sel(idx) !== val) miss("wait ran out");
   endtask

   task automatic reset_lock();
      button_in = 1'b1;
      repeat (2 * TK) @(negedge clk);
      button_in = 1'b0;
      wait_sig(4, 1'b0, 8, n);
      // the write pulse stands only in this cycle, so look at the pins now
      chk_cause(nv_cause, C_NONE);
      chk_bit(nv_write, 1'b1, "clear not written");
      wait_sig(0, 1'b1, 8, n);
   endtask

   task automatic t_powerup();
      wait_sig(0, 1'b1, 20, n);
      wait_sig(4, 1'b1, 200, n);
      chk_int(n, PWRFAN_T * TK, "power-up fan time");
      chk_bit(fan, 1'b0, "fan in lock");
      chk_cause(nv_cause, C_THERMO);
      nv_stored = 3'h0;
      reset_lock();
   endtask

   // power cycle with the last stored cause fed back from the cell
   task automatic t_recall();
      @(negedge clk);
      arst_n = 1'b0;
      nv_stored = 3'(last_cause);
      repeat (2) @(negedge clk);
      chk_bit(alarm | fan, 1'b0, "outputs in reset");
      arst_n = 1'b1;
      wait_sig(0, 1'b1, 20, n);
      wait_sig(4, 1'b1, 200, n);
      chk_cause(nv_cause, C_STRAY);
      chk_bit(nv_write, 1'b0, "write on recall");
      nv_stored = 3'h0;
      reset_lock();
   endtask

   task automatic t_start();
      chk_bit(ignition, 1'b1, "ignition in purge");
      wait_sig(2, 1'b1, 1000, n);
      chk_int(n, PREPURGE_T * TK, "purge length");
      wait_sig(1, 1'b0, 400, n);
      chk_int(n, POSTIGN_T * TK, "post-ignition");
      wait_sig(3, 1'b1, 1000, m);
      chk_int(n + m, STAGE2_T * TK, "second stage delay");
      chk_bit(fan, 1'b1, "fan while running");
      chk_bit(override, 1'b0, "override without preheater");
   endtask

   task automatic t_loss();
      flame_ok = 1'b0;
      repeat (4) @(negedge clk);
      chk_bit(first_stage_valve | second_stage_valve, 1'b0, "valves on loss");
      chk_bit(fan, 1'b1, "post-purge fan");
      chk_bit(alarm, 1'b0, "no lock on loss");
      flame_ok = 1'b1;
      wait_sig(1, 1'b1, 3000, n);
      chk_int(n, POSTPURGE_T * TK, "post-purge time");
   endtask

   task automatic t_undervolt();
      undervolt_in = 1'b1;
      repeat (400) @(negedge clk);
      chk_bit(fan | ignition | alarm, 1'b0, "low mains stop");
      wait_sig(5, 1'b1, 8 * TK, n);
      wait_sig(5, 1'b0, 8 * TK, n);
      undervolt_in = 1'b0;
      wait_sig(0, 1'b1, 3 * TK + 8, n);
   endtask

   task automatic t_noflame();
      flame_ok = 1'b0;
      wait_sig(4, 1'b1, 1200, n);
      chk_cause(nv_cause, C_NOFLAME);
      chk_bit(nv_write, 1'b1, "no-flame cause not written");
      chk_bit(fan | first_stage_valve | ignition, 1'b0, "outputs in lock");
      wait_sig(5, 1'b0, 600, n);
      chk_int(n, LK_LIT_T * TK, "lit phase");
      wait_sig(5, 1'b1, 100, n);
      chk_int(n, LK_DARK_T * TK, "dark phase");
      flame_ok = 1'b1;
      reset_lock();
   endtask

   task automatic t_manual();
      button_in = 1'b1;
      repeat ((HOLD_T + 5) * TK) @(negedge clk);
      button_in = 1'b0;
      wait_sig(4, 1'b1, 8, n);
      chk_cause(nv_cause, C_MANUAL);
      chk_bit(nv_write, 1'b1, "manual cause not written");
      chk_bit(ignition, 1'b0, "ignition in lock");
      reset_lock();
   endtask

   task automatic t_stray();
      stray = 1'b1;
      wait_sig(4, 1'b1, 1000, n);
      chk_int(n, (PREPURGE_T - STRAY_T) * TK, "stray window");
      chk_cause(nv_cause, C_STRAY);
      chk_bit(nv_write, 1'b1, "stray cause not written");
      stray = 1'b0;
   endtask

   // main sequence: power-up with a stored cause, then each phase
   initial begin
      arst_n = 1'b0;
      nv_stored = 3'h3;
      undervolt_in = 1'b0;
      release_in = 1'b0;
      button_in = 1'b0;
      flame_ok = 1'b1;
      stray = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      t_powerup();
      t_start();
      t_loss();
      t_undervolt();
      t_noflame();
      t_manual();
      t_stray();
      t_recall();
      complete_run();
   end
endmodule
